// file: host_transfer_count_and_irq_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module host_transfer_count_and_irq_status_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        byte_mv;
    logic [10:0] ev;
    logic        dma_req;
    logic        fill_upd;
    logic        susp;
    logic        sof_ok;
    logic [31:0] rd;
    logic        perr;
    logic [31:0] seed;
    logic [15:0] nb;
    int          err_count;
    int          tests_run;
    int          fill_cnt = 0;
    logic [15:0] b;

    proc_port_if link ();

    xfer_count_irq_dev i_xfer_count_irq_dev (
        .pclk(pclk), .presetn(presetn), .link(link),
        .end_of_transfer(ev[3]), .byte_moved(byte_mv),
        .dual_role_event(ev[9]), .async_count_hit(ev[8]),
        .async_timeout_hit(ev[10]), .periodic_last_done(ev[7]),
        .periodic_ack_seen(ev[5]), .clock_resumed(ev[6]),
        .operational_event(ev[4]), .iso_buffer_one_event(ev[2]),
        .iso_buffer_zero_event(ev[1]), .sof_event(ev[0]),
        .dma_request(dma_req), .buffer_fill_update(fill_upd),
        .suspended(susp), .sof_send_allowed(sof_ok));

    xfer_count_irq_host i_xfer_count_irq_host (
        .pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));

    xfer_count_irq_props i_xfer_count_irq_props (
        .pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .cmd_wdata(link.cmd_wdata),
        .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata),
        .irq_pin_one(link.irq_pin_one));

    always #10 pclk = ~pclk;
    always @(posedge pclk) if (fill_upd === 1'b1) fill_cnt <= fill_cnt + 1;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Status bit left behind by a pulse on one event line; the ACK
    // line alone sets nothing, the timeout shares the async bit
    function automatic logic [15:0] exp_flag(input int i);
        if (i == 5)
            return 16'h0000;
        return 16'h0001 << ((i == 10) ? 8 : i);
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic ran_out;
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    // Entered just after an edge; leaves one idle edge so that no
    // signal is assigned twice in one time step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) ran_out();
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // One device command through the host; the answer lands in rd
    task automatic cmd(input logic [7:0] c, input logic [15:0] d);
        int n;
        apb(1'b1, 8'h00, {8'h00, c, d});
        n = 0;
        do begin
            apb(1'b0, 8'h08, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 20);
        if (n >= 20) ran_out();
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
    endtask

    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        // The periodic flag needs the ACK line high in the same cycle
        if (i == 7)
            ev[5] <= 1'b1;
        @(posedge pclk);
        ev <= 11'h000;
        repeat (6) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, byte_mv} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ev = 11'h000;
        seed = 32'h636D;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmd(8'h22, 16'h0000);
        check(rd, 32'h0);
        cmd(8'h24, 16'h0000);
        check(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, perr}, 32'h1);
        $display("test reset values done");
        // Count is held while the count enable is off
        repeat (6) begin
            seed = lfsr(seed);
            cmd(8'hA2, seed[15:0]);
            byte_mv <= 1'b1;
            repeat (3) @(posedge pclk);
            byte_mv <= 1'b0;
            @(posedge pclk);
            cmd(8'h22, 16'h0000);
            check(rd, {16'h0, seed[15:0]});
        end
        $display("test count load done");
        nb = {13'h0, seed[2:0]} + 16'h2;
        cmd(8'hA4, 16'h03FF);
        cmd(8'hA2, nb);
        cmd(8'hA1, 16'h0090);
        check({31'h0, dma_req}, 32'h1);
        repeat (nb) begin
            byte_mv <= 1'b1;
            @(posedge pclk);
            byte_mv <= 1'b0;
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        check(fill_cnt, 32'h1);
        check({31'h0, dma_req}, 32'h0);
        cmd(8'h22, 16'h0000);
        check(rd, 32'h0);
        cmd(8'h24, 16'h0000);
        check(rd, 32'h8);
        cmd(8'hA1, 16'h0000);
        $display("test count run done");
        for (int i = 0; i < 11; i++) begin
            b = exp_flag(i);
            cmd(8'hA4, 16'h03FF);
            pulse(i);
            cmd(8'h24, 16'h0000);
            check(rd, {16'h0, b});
            cmd(8'hA4, 16'h0000);
            cmd(8'h24, 16'h0000);
            check(rd, {16'h0, b});
            cmd(8'hA4, b);
            cmd(8'h24, 16'h0000);
            check(rd, 32'h0);
        end
        cmd(8'hA4, 16'h03FF);
        cmd(8'hA7, 16'h00C0);
        check({30'h0, susp, sof_ok}, 32'h2);
        // A frame tick while suspended must leave its flag clear
        pulse(0);
        cmd(8'h24, 16'h0000);
        check(rd, 32'h20);
        cmd(8'hA7, 16'h0000);
        $display("test event flags done");
        cmd(8'hA4, 16'h03FF);
        cmd(8'hA5, 16'h0001);
        cmd(8'hA0, 16'h0001);
        apb(1'b1, 8'h0C, 32'h2);
        pulse(0);
        check({31'h0, link.irq_pin_one}, 32'h1);
        check({31'h0, irq}, 32'h1);
        cmd(8'hA0, 16'h0000);
        check({31'h0, link.irq_pin_one}, 32'h0);
        cmd(8'hA0, 16'h0001);
        cmd(8'hA5, 16'h0000);
        check({31'h0, link.irq_pin_one}, 32'h0);
        cmd(8'hA5, 16'h0001);
        check({31'h0, link.irq_pin_one}, 32'h1);
        cmd(8'hA4, 16'h00FF);
        check({31'h0, link.irq_pin_one}, 32'h0);
        apb(1'b1, 8'h08, 32'h2);
        check({31'h0, irq}, 32'h0);
        $display("test interrupt pin done");
        // A second reset in mid-run must bring count and flags back
        seed = lfsr(seed);
        cmd(8'hA2, seed[15:0] | 16'h0001);
        pulse(9);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmd(8'h22, 16'h0000);
        check(rd, 32'h0);
        cmd(8'h24, 16'h0000);
        check(rd, 32'h0);
        $display("test mid-run reset done");
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        ran_out();
    end
endmodule

`default_nettype wire

// file: host_xfer_defines.svh
`ifndef HOST_XFER_DEFINES_SVH
`define HOST_XFER_DEFINES_SVH

// Command codes on the parallel register port, bit 7 set means write
`define CODE_WRITE_BIT      7
`define CODE_HW_SETUP_RD    8'h20
`define CODE_HW_SETUP_WR    8'hA0
`define CODE_DMA_SETUP_RD   8'h21
`define CODE_DMA_SETUP_WR   8'hA1
`define CODE_BYTE_COUNT_RD  8'h22
`define CODE_BYTE_COUNT_WR  8'hA2
`define CODE_IRQ_STATUS_RD  8'h24
`define CODE_IRQ_STATUS_WR  8'hA4
`define CODE_IRQ_MASK_RD    8'h25
`define CODE_IRQ_MASK_WR    8'hA5
`define CODE_HOST_CTRL_RD   8'h27
`define CODE_HOST_CTRL_WR   8'hA7

// Field positions
`define GLOBAL_IRQ_EN_BIT   0
`define COUNT_EN_BIT        7
`define DMA_RUN_BIT         4
`define SUSPEND_LO_BIT      6
`define SUSPEND_HI_BIT      7
`define FLAG_DUAL_ROLE      9
`define FLAG_ASYNC_LIST     8
`define FLAG_PERIODIC_LIST  7
`define FLAG_CLOCK_RESUMED  6
`define FLAG_SUSPENDED      5
`define FLAG_OPERATIONAL    4
`define FLAG_ALL_DONE       3
`define FLAG_ISO_ONE        2
`define FLAG_ISO_ZERO       1
`define FLAG_SOF            0

// Reset values
`define BYTE_COUNT_RESET    16'h0000
`define IRQ_STATUS_RESET    10'h000
`define IRQ_MASK_RESET      10'h000
`define DMA_SETUP_RESET     8'h00
`define HW_SETUP_RESET      16'h0000
`define HOST_CTRL_RESET     8'h00

// Host controller APB map
`define APB_CMD_OFFSET      8'h00
`define APB_RDATA_OFFSET    8'h04
`define APB_STATUS_OFFSET   8'h08
`define APB_MASK_OFFSET     8'h0C
`define APB_STATE_OFFSET    8'h10
`define APB_CMD_CODE_LSB    16
`define HOST_EV_DONE        0
`define HOST_EV_DEV_IRQ     1

`endif

// file: host_xfer_pkg.sv
`default_nettype none

package host_xfer_pkg;

    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  dma_cfg;
        logic [9:0]  status;
        logic [9:0]  mask;
        logic [15:0] hw_cfg;
        logic [7:0]  ctrl;
        logic        rsp_valid;
        logic [15:0] rsp_data;
        logic        eot_s1;
        logic        eot_s2;
        logic        eot_d;
        logic        irq;
        logic        dma_req;
        logic        fill_upd;
    } dev_state_t;

    typedef struct packed {
        logic        busy;
        logic        cmd_valid;
        logic [7:0]  cmd_code;
        logic [15:0] cmd_wdata;
        logic [15:0] rdata;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        pin_d;
        logic        irq;
    } host_state_t;

endpackage

`default_nettype wire

// file: proc_port_if.sv
`timescale 1ns/1ps
`default_nettype none

interface proc_port_if;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic        irq_pin_one;

    modport device (
        input  cmd_valid,
        input  cmd_code,
        input  cmd_wdata,
        output rsp_valid,
        output rsp_rdata,
        output irq_pin_one
    );

    modport host (
        output cmd_valid,
        output cmd_code,
        output cmd_wdata,
        input  rsp_valid,
        input  rsp_rdata,
        input  irq_pin_one
    );
endinterface

`default_nettype wire

// file: xfer_count_irq_dev.sv
`include "host_xfer_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module xfer_count_irq_dev (
    input  wire logic       pclk,
    input  wire logic       presetn,
    proc_port_if.device     link,
    input  wire logic       end_of_transfer,
    input  wire logic       byte_moved,
    input  wire logic       dual_role_event,
    input  wire logic       async_count_hit,
    input  wire logic       async_timeout_hit,
    input  wire logic       periodic_last_done,
    input  wire logic       periodic_ack_seen,
    input  wire logic       clock_resumed,
    input  wire logic       operational_event,
    input  wire logic       iso_buffer_one_event,
    input  wire logic       iso_buffer_zero_event,
    input  wire logic       sof_event,
    output logic            dma_request,
    output logic            buffer_fill_update,
    output logic            suspended,
    output logic            sof_send_allowed
);
    import host_xfer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    host_xfer_pkg::dev_state_t s_r;
    host_xfer_pkg::dev_state_t s_nxt;

    logic        is_write;
    logic        count_done;
    logic        eot_edge;
    logic        in_suspend;
    logic        entering_suspend;
    logic [9:0]  events;
    logic [9:0]  clear_bits;
    logic [7:0]  ctrl_new;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.fill_upd  = 1'b0;
        clear_bits = 10'h000;
        ctrl_new   = s_r.ctrl;
        is_write   = link.cmd_valid & link.cmd_code[`CODE_WRITE_BIT];

        // Pin passes two flops before the edge detector looks at it
        s_nxt.eot_s1 = end_of_transfer;
        s_nxt.eot_s2 = s_r.eot_s1;
        s_nxt.eot_d  = s_r.eot_s2;
        eot_edge     = s_r.eot_s2 & ~s_r.eot_d;

        // Counter runs for PIO and DMA alike, only when enabled
        count_done = 1'b0;
        if (s_r.dma_cfg[`COUNT_EN_BIT] && byte_moved &&
            s_r.count != 16'h0000) begin
            s_nxt.count = s_r.count - 16'h0001;
            if (s_r.count == 16'h0001) begin
                count_done = 1'b1;
            end
        end
        s_nxt.fill_upd = count_done;

        // Register writes; a write to the count wins over a decrement
        if (is_write) begin
            unique case (link.cmd_code)
                `CODE_BYTE_COUNT_WR: begin
                    s_nxt.count = link.cmd_wdata;
                end
                `CODE_IRQ_STATUS_WR: begin
                    clear_bits = link.cmd_wdata[9:0];
                end
                `CODE_IRQ_MASK_WR: begin
                    s_nxt.mask = link.cmd_wdata[9:0];
                end
                `CODE_DMA_SETUP_WR: begin
                    s_nxt.dma_cfg = link.cmd_wdata[7:0];
                end
                `CODE_HW_SETUP_WR: begin
                    s_nxt.hw_cfg = link.cmd_wdata;
                end
                `CODE_HOST_CTRL_WR: begin
                    ctrl_new = link.cmd_wdata[7:0];
                end
                default: begin
                    clear_bits = 10'h000;
                end
            endcase
        end
        s_nxt.ctrl = ctrl_new;

        // Suspend is both control bits high
        in_suspend = s_r.ctrl[`SUSPEND_HI_BIT] &
                     s_r.ctrl[`SUSPEND_LO_BIT];
        entering_suspend = ctrl_new[`SUSPEND_HI_BIT] &
                           ctrl_new[`SUSPEND_LO_BIT] & ~in_suspend;

        // Event vector in flag order
        events = 10'h000;
        events[`FLAG_DUAL_ROLE]     = dual_role_event;
        events[`FLAG_ASYNC_LIST]    = async_count_hit |
                                      async_timeout_hit;
        events[`FLAG_PERIODIC_LIST] = periodic_last_done &
                                      periodic_ack_seen;
        events[`FLAG_CLOCK_RESUMED] = clock_resumed;
        events[`FLAG_SUSPENDED]     = entering_suspend;
        events[`FLAG_OPERATIONAL]   = operational_event;
        events[`FLAG_ALL_DONE]      = count_done | eot_edge;
        events[`FLAG_ISO_ONE]       = iso_buffer_one_event;
        events[`FLAG_ISO_ZERO]      = iso_buffer_zero_event;
        // SOF events are dropped while suspended, none go downstream
        events[`FLAG_SOF]           = sof_event & ~in_suspend;

        // Set wins over a clear arriving in the same cycle
        s_nxt.status = (s_r.status & ~clear_bits) | events;

        // Every command gets an answer one cycle later
        if (link.cmd_valid) begin
            s_nxt.rsp_valid = 1'b1;
            unique case (link.cmd_code)
                `CODE_BYTE_COUNT_RD: begin
                    s_nxt.rsp_data = s_r.count;
                end
                `CODE_IRQ_STATUS_RD: begin
                    s_nxt.rsp_data = {6'h00, s_r.status};
                end
                `CODE_IRQ_MASK_RD: begin
                    s_nxt.rsp_data = {6'h00, s_r.mask};
                end
                `CODE_DMA_SETUP_RD: begin
                    s_nxt.rsp_data = {8'h00, s_r.dma_cfg};
                end
                `CODE_HW_SETUP_RD: begin
                    s_nxt.rsp_data = s_r.hw_cfg;
                end
                `CODE_HOST_CTRL_RD: begin
                    s_nxt.rsp_data = {8'h00, s_r.ctrl};
                end
                default: begin
                    s_nxt.rsp_data = 16'h0000;
                end
            endcase
        end

        // Pin follows the registered flags, so it lags a flag by a cycle
        s_nxt.irq = s_r.hw_cfg[`GLOBAL_IRQ_EN_BIT] &
                    (|(s_r.status & s_r.mask));

        // No request without an enabled, nonzero count
        s_nxt.dma_req = s_nxt.dma_cfg[`DMA_RUN_BIT] &
                        s_nxt.dma_cfg[`COUNT_EN_BIT] &
                        (s_nxt.count != 16'h0000);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.count     <= `BYTE_COUNT_RESET;
            s_r.dma_cfg   <= `DMA_SETUP_RESET;
            s_r.status    <= `IRQ_STATUS_RESET;
            s_r.mask      <= `IRQ_MASK_RESET;
            s_r.hw_cfg    <= `HW_SETUP_RESET;
            s_r.ctrl      <= `HOST_CTRL_RESET;
            s_r.rsp_valid <= 1'b0;
            s_r.rsp_data  <= 16'h0000;
            s_r.eot_s1    <= 1'b0;
            s_r.eot_s2    <= 1'b0;
            s_r.eot_d     <= 1'b0;
            s_r.irq       <= 1'b0;
            s_r.dma_req   <= 1'b0;
            s_r.fill_upd  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.rsp_valid   = s_r.rsp_valid;
    assign link.rsp_rdata   = s_r.rsp_data;
    assign link.irq_pin_one = s_r.irq;
    assign dma_request        = s_r.dma_req;
    assign buffer_fill_update = s_r.fill_upd;
    assign suspended          = s_r.ctrl[`SUSPEND_HI_BIT] &
                                s_r.ctrl[`SUSPEND_LO_BIT];
    assign sof_send_allowed   = ~suspended;

endmodule

`default_nettype wire

// file: xfer_count_irq_host.sv
`include "host_xfer_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module xfer_count_irq_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    proc_port_if.host        link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    import host_xfer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    host_xfer_pkg::host_state_t s_r;
    host_xfer_pkg::host_state_t s_nxt;

    logic       access;
    logic       mapped;
    logic [1:0] events;
    logic [1:0] clear_bits;

    assign access = psel & penable;
    assign mapped = (paddr == `APB_CMD_OFFSET)    |
                    (paddr == `APB_RDATA_OFFSET)  |
                    (paddr == `APB_STATUS_OFFSET) |
                    (paddr == `APB_MASK_OFFSET)   |
                    (paddr == `APB_STATE_OFFSET);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd_valid = 1'b0;
        clear_bits = 2'b00;
        events     = 2'b00;

        // A command write while one is in flight is dropped
        if (access && pwrite && paddr == `APB_CMD_OFFSET && !s_r.busy) begin
            s_nxt.cmd_valid = 1'b1;
            s_nxt.busy      = 1'b1;
            s_nxt.cmd_code  = pwdata[`APB_CMD_CODE_LSB +: 8];
            s_nxt.cmd_wdata = pwdata[15:0];
        end
        if (access && pwrite && paddr == `APB_STATUS_OFFSET) begin
            clear_bits = pwdata[1:0];
        end
        if (access && pwrite && paddr == `APB_MASK_OFFSET) begin
            s_nxt.mask = pwdata[1:0];
        end

        if (s_r.busy && link.rsp_valid) begin
            s_nxt.busy  = 1'b0;
            s_nxt.rdata = link.rsp_rdata;
            events[`HOST_EV_DONE] = 1'b1;
        end
        s_nxt.pin_d = link.irq_pin_one;
        events[`HOST_EV_DEV_IRQ] = link.irq_pin_one & ~s_r.pin_d;

        // Set wins over a clear in the same cycle
        s_nxt.status = (s_r.status & ~clear_bits) | events;
        s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `APB_CMD_OFFSET: begin
                prdata = {8'h00, s_r.cmd_code, s_r.cmd_wdata};
            end
            `APB_RDATA_OFFSET: begin
                prdata = {16'h0000, s_r.rdata};
            end
            `APB_STATUS_OFFSET: begin
                prdata = {30'h0000_0000, s_r.status};
            end
            `APB_MASK_OFFSET: begin
                prdata = {30'h0000_0000, s_r.mask};
            end
            `APB_STATE_OFFSET: begin
                prdata = {30'h0000_0000, link.irq_pin_one, s_r.busy};
            end
            default: begin
                prdata = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.cmd_valid = s_r.cmd_valid;
    assign link.cmd_code  = s_r.cmd_code;
    assign link.cmd_wdata = s_r.cmd_wdata;
    assign irq            = s_r.irq;

endmodule

`default_nettype wire

// file: xfer_count_irq_props.sv
`timescale 1ns/1ps
`default_nettype none

module xfer_count_irq_props (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic        irq_pin_one
);
    logic glob_r;
    logic mask_r;
    logic wr_cmd;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Shadow of global enable and of any mask bit, seen on the link
    assign wr_cmd = cmd_valid & cmd_code[7];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glob_r <= 1'b0;
            mask_r <= 1'b0;
        end else if (cmd_valid && cmd_code == 8'hA0) begin
            glob_r <= cmd_wdata[0];
        end else if (cmd_valid && cmd_code == 8'hA5) begin
            mask_r <= |cmd_wdata[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_answer_follows:
    assert property (cmd_valid |=> rsp_valid)
        else $error("command got no answer");
    chk_answer_single:
    assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    chk_answer_asked:
    assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without command");
    chk_reserved_zero:
    assert property (rsp_valid && $past(cmd_code) == 8'h24
                     |-> rsp_rdata[15:10] == 6'h00)
        else $error("reserved status bits not zero");
    // Two cycles of slack: the pin is registered behind the enables
    chk_irq_global:
    assert property (irq_pin_one
                     |-> glob_r || $past(glob_r) || $past(glob_r, 2))
        else $error("pin high with global enable off");
    chk_irq_masked:
    assert property (irq_pin_one
                     |-> mask_r || $past(mask_r) || $past(mask_r, 2))
        else $error("pin high with all mask bits off");
    // The pin is registered, so it rose on the enables of an edge ago
    chk_irq_rise_enabled:
    assert property ($rose(irq_pin_one) |-> $past(glob_r) && $past(mask_r))
        else $error("pin rose while not enabled");
    chk_irq_drop_write:
    assert property ($fell(irq_pin_one)
                     |-> $past(wr_cmd) || $past(wr_cmd, 2))
        else $error("pin fell without a register write");

    cover property (rsp_valid && $past(cmd_code) == 8'h24);
    cover property ($rose(irq_pin_one));
    cover property ($fell(irq_pin_one));
endmodule

`default_nettype wire
